// File: logic/srct_pkg.sv
`default_nettype none
// ============================================================
// shared constants of the split reload capture timer
package srct_pkg;

  // ============================================================
  // register offsets on the 8-bit register port
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_CLOCK_CONTROL = 8'h01;
  localparam logic [7:0] ADDR_COUNT_LOW = 8'h02;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'h03;
  localparam logic [7:0] ADDR_RELOAD_LOW = 8'h04;
  localparam logic [7:0] ADDR_RELOAD_HIGH = 8'h05;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h06;
  localparam logic [7:0] ADDR_EVENT_STATUS = 8'h07;
  localparam logic [7:0] ADDR_EVENT_MASK = 8'h08;

  // ============================================================
  // timer_two_control field positions
  localparam int unsigned CTL_HIGH_FLAG = 7;
  localparam int unsigned CTL_LOW_FLAG = 6;
  localparam int unsigned CTL_LOW_IRQ_EN = 5;
  localparam int unsigned CTL_CAPTURE_EN = 4;
  localparam int unsigned CTL_SPLIT = 3;
  localparam int unsigned CTL_RUN = 2;
  localparam int unsigned CTL_EXT_SEL_HI = 1;
  localparam int unsigned CTL_EXT_SEL_LO = 0;
  localparam logic [5:0] CTL_RESET = 6'h00;

  // ============================================================
  // clock_control_register and irq enable fields
  localparam int unsigned CKC_LOW_FAST = 4;
  localparam int unsigned CKC_HIGH_FAST = 5;
  localparam logic [1:0] CKC_RESET = 2'h0;
  localparam int unsigned IEN_TIMER_TWO = 0;

  // ============================================================
  // event status bits, read clears
  localparam int unsigned EV_HIGH_OVF = 0;
  localparam int unsigned EV_LOW_OVF = 1;
  localparam int unsigned EV_CAPTURE = 2;
  localparam int unsigned EV_WIDTH = 3;

  // ============================================================
  // external clock select codes
  typedef enum logic [1:0] {
    SRCT_SRC_DIV12 = 2'h0,
    SRCT_SRC_RTC8 = 2'h1,
    SRCT_SRC_RESERVED = 2'h2,
    SRCT_SRC_COMP = 2'h3
  } srct_src_t;

  // ============================================================
  // dividers and count values
  localparam logic [3:0] SYS_DIV_LAST = 4'hb;
  localparam logic [2:0] RTC_DIV_LAST = 3'h7;
  localparam logic [7:0] BYTE_ALL_ONES = 8'hff;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

endpackage : srct_pkg
`default_nettype wire

// File: logic/srct_half_if.sv
`default_nettype none
// ============================================================
// link between the timer core and one 8-bit count half
interface srct_half_if;
  logic tick;
  logic reload_en;
  logic [7:0] reload_val;
  logic sw_wr;
  logic [7:0] sw_data;
  logic [7:0] count;
  logic wrap;
  modport ctrl (output tick, output reload_en, output reload_val, output sw_wr,
                output sw_data, input count, input wrap);
  modport half (input tick, input reload_en, input reload_val, input sw_wr,
                input sw_data, output count, output wrap);
endinterface : srct_half_if
`default_nettype wire

// File: logic/srct_tick_gen.sv
`default_nettype none
module srct_tick_gen (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // slow sources
  input wire logic rtc_clk_in,
  input wire logic comparator_in,
  // one-cycle enables
  output logic div12_tick,
  output logic rtc8_tick,
  output logic comp_rise
);
  // ============================================================
  // synchronisers, the first stage feeds only the second
  logic rtc_s1, rtc_s2, rtc_s3;
  logic cmp_s1, cmp_s2, cmp_s3;
  logic [3:0] sys_div_reg;
  logic [2:0] rtc_div_reg;
  logic rtc_rise;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rtc_s1 <= 1'b0;
      rtc_s2 <= 1'b0;
      rtc_s3 <= 1'b0;
      cmp_s1 <= 1'b0;
      cmp_s2 <= 1'b0;
      cmp_s3 <= 1'b0;
    end else begin
      rtc_s1 <= rtc_clk_in;
      rtc_s2 <= rtc_s1;
      rtc_s3 <= rtc_s2;
      cmp_s1 <= comparator_in;
      cmp_s2 <= cmp_s1;
      cmp_s3 <= cmp_s2;
    end
  end

  assign rtc_rise = rtc_s2 & ~rtc_s3;
  assign comp_rise = cmp_s2 & ~cmp_s3;
  assign div12_tick = (sys_div_reg == srct_pkg::SYS_DIV_LAST);
  assign rtc8_tick = rtc_rise & (rtc_div_reg == srct_pkg::RTC_DIV_LAST);

  // ============================================================
  // dividers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sys_div_reg <= 4'h0;
      rtc_div_reg <= 3'h0;
    end else begin
      sys_div_reg <= div12_tick ? 4'h0 : sys_div_reg + 4'h1;
      if (rtc_rise) begin
        rtc_div_reg <= rtc_div_reg + 3'h1;
      end
    end
  end

  chk_div12_period: assert property (@(posedge clk) disable iff (!rstn)
    div12_tick |-> ##12 div12_tick)
    else $error("core clock divide by 12 period wrong");
endmodule : srct_tick_gen
`default_nettype wire

// File: logic/srct_half_counter.sv
`default_nettype none
module srct_half_counter (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // core link
  srct_half_if.half hb
);
  logic [7:0] count_reg;
  logic [7:0] count_next;
  logic at_top;

  assign at_top = (count_reg == srct_pkg::BYTE_ALL_ONES);
  assign hb.wrap = hb.tick & at_top;
  assign hb.count = count_reg;
  // a wrap without reload simply rolls to zero, which chains the 16-bit pair
  assign count_next = (at_top && hb.reload_en) ? hb.reload_val : count_reg + 8'h01;

  // software write beats a tick in the same cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count_reg <= srct_pkg::BYTE_ZERO;
    end else if (hb.sw_wr) begin
      count_reg <= hb.sw_data;
    end else if (hb.tick) begin
      count_reg <= count_next;
    end
  end

  chk_half_hold: assert property (@(posedge clk) disable iff (!rstn)
    !hb.tick && !hb.sw_wr |=> $stable(count_reg))
    else $error("count half moved without a tick");
endmodule : srct_half_counter
`default_nettype wire

// File: logic/srct_timer.sv
`default_nettype none
module srct_timer (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // slow clock sources
  input wire logic rtc_clk_in,
  input wire logic comparator_in,
  // interrupt
  output logic irq
);
  // ============================================================
  // state
  logic [5:0] ctrl_reg;
  logic high_flag_reg;
  logic low_flag_reg;
  logic [1:0] ckc_reg;
  logic irq_en_reg;
  logic [7:0] reload_low_reg;
  logic [7:0] reload_high_reg;
  logic [srct_pkg::EV_WIDTH-1:0] ev_status_reg;
  logic [srct_pkg::EV_WIDTH-1:0] ev_mask_reg;
  logic [7:0] rdata_reg;
  logic irq_reg;
  logic [7:0] rdata_next;
  logic irq_next;
  logic high_flag_next;
  logic low_flag_next;
  logic [srct_pkg::EV_WIDTH-1:0] ev_status_next;

  srct_half_if lo_if ();
  srct_half_if hi_if ();

  logic div12_tick, rtc8_tick, comp_rise;

  // ============================================================
  // submodules
  srct_tick_gen u_ticks (
    .clk(clk),
    .rstn(rstn),
    .rtc_clk_in(rtc_clk_in),
    .comparator_in(comparator_in),
    .div12_tick(div12_tick),
    .rtc8_tick(rtc8_tick),
    .comp_rise(comp_rise)
  );

  srct_half_counter u_low (
    .clk(clk),
    .rstn(rstn),
    .hb(lo_if.half)
  );

  srct_half_counter u_high (
    .clk(clk),
    .rstn(rstn),
    .hb(hi_if.half)
  );

  // ============================================================
  // clock source selection
  function automatic logic half_tick(input logic fast, input logic [1:0] sel,
                                     input logic d12, input logic r8, input logic cmp);
    logic t;
    t = 1'b0;
    if (fast) begin
      t = 1'b1;
    end else begin
      case (sel)
        srct_pkg::SRCT_SRC_DIV12: t = d12;
        srct_pkg::SRCT_SRC_RTC8: t = r8;
        srct_pkg::SRCT_SRC_COMP: t = cmp;
        default: t = 1'b0;
      endcase
    end
    return t;
  endfunction

  // ============================================================
  // decode
  wire split = ctrl_reg[srct_pkg::CTL_SPLIT];
  wire run = ctrl_reg[srct_pkg::CTL_RUN];
  wire cap_mode = ctrl_reg[srct_pkg::CTL_CAPTURE_EN];
  wire low_irq_en = ctrl_reg[srct_pkg::CTL_LOW_IRQ_EN];
  wire [1:0] ext_sel = ctrl_reg[srct_pkg::CTL_EXT_SEL_HI:srct_pkg::CTL_EXT_SEL_LO];
  wire wr_ctrl = reg_wr && (reg_addr == srct_pkg::ADDR_CONTROL);
  wire wr_ckc = reg_wr && (reg_addr == srct_pkg::ADDR_CLOCK_CONTROL);
  wire wr_cnt_lo = reg_wr && (reg_addr == srct_pkg::ADDR_COUNT_LOW);
  wire wr_cnt_hi = reg_wr && (reg_addr == srct_pkg::ADDR_COUNT_HIGH);
  wire wr_rld_lo = reg_wr && (reg_addr == srct_pkg::ADDR_RELOAD_LOW);
  wire wr_rld_hi = reg_wr && (reg_addr == srct_pkg::ADDR_RELOAD_HIGH);
  wire wr_ien = reg_wr && (reg_addr == srct_pkg::ADDR_IRQ_ENABLE);
  wire wr_mask = reg_wr && (reg_addr == srct_pkg::ADDR_EVENT_MASK);
  wire rd_status = reg_rd && (reg_addr == srct_pkg::ADDR_EVENT_STATUS);

  wire low_src = half_tick(ckc_reg[0], ext_sel, div12_tick, rtc8_tick, comp_rise);
  wire high_src = half_tick(ckc_reg[1], ext_sel, div12_tick, rtc8_tick, comp_rise);
  wire hi_at_top = (hi_if.count == srct_pkg::BYTE_ALL_ONES);
  // a full wrap in 16-bit capture is not an overflow event
  wire carry_mode = ~split & cap_mode;

  // ============================================================
  // half control
  assign lo_if.tick = split ? low_src : (run & low_src);
  assign hi_if.tick = split ? (run & high_src) : lo_if.wrap;
  // 16-bit capture keeps the reload pair for captured values, so the count free-runs; split halves still reload
  assign lo_if.reload_en = split | (hi_at_top & ~cap_mode);
  assign hi_if.reload_en = split | ~cap_mode;
  assign lo_if.reload_val = reload_low_reg;
  assign hi_if.reload_val = reload_high_reg;
  assign lo_if.sw_wr = wr_cnt_lo;
  assign hi_if.sw_wr = wr_cnt_hi;
  assign lo_if.sw_data = reg_wdata;
  assign hi_if.sw_data = reg_wdata;

  // ============================================================
  // events
  wire capture_evt = cap_mode & (ext_sel[1] ? comp_rise : rtc8_tick);
  wire high_ovf = hi_if.wrap & ~carry_mode;
  wire low_ovf = lo_if.wrap;
  wire [srct_pkg::EV_WIDTH-1:0] ev_set = {capture_evt, low_ovf, high_ovf};

  // set always wins over a software clear
  assign high_flag_next = high_ovf | capture_evt |
                          (wr_ctrl ? reg_wdata[srct_pkg::CTL_HIGH_FLAG] : high_flag_reg);
  assign low_flag_next = low_ovf |
                         (wr_ctrl ? reg_wdata[srct_pkg::CTL_LOW_FLAG] : low_flag_reg);
  assign ev_status_next = ev_set | (rd_status ? {srct_pkg::EV_WIDTH{1'b0}} : ev_status_reg);
  assign irq_next = (irq_en_reg & (high_flag_next | (low_irq_en & low_flag_next))) |
                    (|(ev_status_next & ev_mask_reg));

  // ============================================================
  // read mux
  always_comb begin
    rdata_next = 8'h00;
    if (reg_addr == srct_pkg::ADDR_CONTROL) begin
      rdata_next = {high_flag_reg, low_flag_reg, ctrl_reg};
    end else if (reg_addr == srct_pkg::ADDR_CLOCK_CONTROL) begin
      rdata_next = {2'h0, ckc_reg, 4'h0};
    end else if (reg_addr == srct_pkg::ADDR_COUNT_LOW) begin
      rdata_next = lo_if.count;
    end else if (reg_addr == srct_pkg::ADDR_COUNT_HIGH) begin
      rdata_next = hi_if.count;
    end else if (reg_addr == srct_pkg::ADDR_RELOAD_LOW) begin
      rdata_next = reload_low_reg;
    end else if (reg_addr == srct_pkg::ADDR_RELOAD_HIGH) begin
      rdata_next = reload_high_reg;
    end else if (reg_addr == srct_pkg::ADDR_IRQ_ENABLE) begin
      rdata_next = {7'h00, irq_en_reg};
    end else if (reg_addr == srct_pkg::ADDR_EVENT_STATUS) begin
      rdata_next = {5'h00, ev_status_reg};
    end else if (reg_addr == srct_pkg::ADDR_EVENT_MASK) begin
      rdata_next = {5'h00, ev_mask_reg};
    end
  end

  // ============================================================
  // registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg <= srct_pkg::CTL_RESET;
      ckc_reg <= srct_pkg::CKC_RESET;
      irq_en_reg <= 1'b0;
      ev_mask_reg <= {srct_pkg::EV_WIDTH{1'b0}};
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= reg_wdata[5:0];
      end
      if (wr_ckc) begin
        ckc_reg <= {reg_wdata[srct_pkg::CKC_HIGH_FAST], reg_wdata[srct_pkg::CKC_LOW_FAST]};
      end
      if (wr_ien) begin
        irq_en_reg <= reg_wdata[srct_pkg::IEN_TIMER_TWO];
      end
      if (wr_mask) begin
        ev_mask_reg <= reg_wdata[srct_pkg::EV_WIDTH-1:0];
      end
    end
  end

  // capture takes the reload pair ahead of a software write
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reload_low_reg <= srct_pkg::BYTE_ZERO;
      reload_high_reg <= srct_pkg::BYTE_ZERO;
    end else if (capture_evt) begin
      reload_low_reg <= lo_if.count;
      reload_high_reg <= hi_if.count;
    end else begin
      if (wr_rld_lo) begin
        reload_low_reg <= reg_wdata;
      end
      if (wr_rld_hi) begin
        reload_high_reg <= reg_wdata;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      high_flag_reg <= 1'b0;
      low_flag_reg <= 1'b0;
      ev_status_reg <= {srct_pkg::EV_WIDTH{1'b0}};
      irq_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      high_flag_reg <= high_flag_next;
      low_flag_reg <= low_flag_next;
      ev_status_reg <= ev_status_next;
      irq_reg <= irq_next;
      rdata_reg <= reg_rd ? rdata_next : 8'h00;
    end
  end

  assign reg_rdata = rdata_reg;
  assign irq = irq_reg;

  // ============================================================
  // checks
  chk_full_reload: assert property (@(posedge clk) disable iff (!rstn)
    !split && !cap_mode && hi_if.wrap && !wr_cnt_lo && !wr_cnt_hi |=>
      {hi_if.count, lo_if.count} == $past({reload_high_reg, reload_low_reg}) &&
      high_flag_reg)
    else $error("16-bit overflow did not reload");

  chk_low_flag_any: assert property (@(posedge clk) disable iff (!rstn)
    lo_if.wrap |=> low_flag_reg)
    else $error("low rollover did not set low flag");

  chk_split_low_reload: assert property (@(posedge clk) disable iff (!rstn)
    split && lo_if.wrap && !wr_cnt_lo |=> lo_if.count == $past(reload_low_reg))
    else $error("split low half did not reload");

  chk_split_high_gate: assert property (@(posedge clk) disable iff (!rstn)
    split && !run && !wr_cnt_hi |=> $stable(hi_if.count))
    else $error("high half counted without run");

  chk_split_low_free: assert property (@(posedge clk) disable iff (!rstn)
    split && !run && low_src && !wr_cnt_lo && lo_if.count != srct_pkg::BYTE_ALL_ONES |=>
      !$stable(lo_if.count))
    else $error("split low half stalled without run");

  chk_split_high_flag: assert property (@(posedge clk) disable iff (!rstn)
    split && hi_if.wrap |=> high_flag_reg ##1 high_flag_reg || $past(wr_ctrl))
    else $error("split high rollover lost its flag");

  chk_capture_copy: assert property (@(posedge clk) disable iff (!rstn)
    capture_evt |=> {reload_high_reg, reload_low_reg} == $past({hi_if.count, lo_if.count})
      && high_flag_reg)
    else $error("capture did not copy the count");

  chk_capture_source: assert property (@(posedge clk) disable iff (!rstn)
    cap_mode && ext_sel[1] && !comp_rise && !wr_rld_lo |=> $stable(reload_low_reg))
    else $error("capture fired without a comparator edge");

  chk_flag_sticky: assert property (@(posedge clk) disable iff (!rstn)
    high_flag_reg && !wr_ctrl |=> high_flag_reg)
    else $error("high flag cleared without software");

  chk_irq_main: assert property (@(posedge clk) disable iff (!rstn)
    irq_en_reg && high_flag_reg && !wr_ctrl && !wr_ien |=> irq)
    else $error("overflow interrupt missing");

  chk_irq_low: assert property (@(posedge clk) disable iff (!rstn)
    irq_en_reg && low_irq_en && low_flag_reg && !wr_ctrl && !wr_ien |=> irq)
    else $error("low byte interrupt missing");

  chk_irq_quiet: assert property (@(posedge clk) disable iff (!rstn)
    !irq_en_reg && !wr_ien && ev_mask_reg == 3'h0 && !wr_mask |=> !irq)
    else $error("interrupt raised while disabled");

  chk_low_wrap_irq: assert property (@(posedge clk) disable iff (!rstn)
    !split && irq_en_reg && low_irq_en && lo_if.wrap |=> irq)
    else $error("low byte rollover interrupt missing");

  chk_split_high_irq: assert property (@(posedge clk) disable iff (!rstn)
    split && irq_en_reg && hi_if.wrap |=> irq)
    else $error("split high rollover interrupt missing");

  chk_capture_no_reload: assert property (@(posedge clk) disable iff (!rstn)
    !split && cap_mode && hi_if.wrap && !wr_cnt_lo && !wr_cnt_hi |=>
      {hi_if.count, lo_if.count} == 16'h0000)
    else $error("capture mode overwrote the count with reload");
endmodule : srct_timer
`default_nettype wire

// File: verif/srct_timer_bench.sv
`default_nettype none
module srct_timer_bench;
  timeunit 1ns;
  timeprecision 1ps;

  // ============================================================
  // design hookup
  logic clk;
  logic rstn;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic rtc_clk_in;
  logic comparator_in;
  logic irq;
  int bad_count = 0;
  int compares = 0;
  int cycles = 0;
  int t0;
  logic [7:0] v;
  logic [15:0] cap1;
  logic [15:0] cap2;

  srct_timer srct_timer_inst (
    .clk(clk),
    .rstn(rstn),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .rtc_clk_in(rtc_clk_in),
    .comparator_in(comparator_in),
    .irq(irq)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ============================================================
  // hang guard, a few thousand cycles is ample for all tests
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      bad_count = bad_count + 1;
      $display("[FAIL] %0t run too long", $time);
      end_sim();
    end
  end

  // ============================================================
  // bus and check helpers
  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // data stands only in the cycle after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic chk(input bit ok, input string m);
    compares++;
    if (!ok) begin
      bad_count++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask

  task automatic cmp_pulses(input int n);
    repeat (n) begin
      @(posedge clk);
      comparator_in <= 1'b1;
      idle(4);
      comparator_in <= 1'b0;
      idle(3);
    end
  endtask

  task automatic rtc_cycles(input int n);
    repeat (n) begin
      @(posedge clk);
      rtc_clk_in <= 1'b1;
      idle(3);
      rtc_clk_in <= 1'b0;
      idle(2);
    end
  endtask

  // ============================================================
  // scenarios
  task automatic t_reset();
    for (int a = 0; a < 9; a++) begin
      rd(8'(a), v);
      chk(v === 8'h00, "reset value");
    end
    wr(8'h09, 8'hff);
    rd(8'h09, v);
    chk(v === 8'h00, "unmapped read");
    chk(irq === 1'b0, "irq at reset");
    $display("t_reset done");
  endtask

  task automatic t_wide();
    wr(8'h01, 8'h10);
    wr(8'h06, 8'h01);
    wr(8'h04, 8'h00);
    wr(8'h05, 8'hff);
    wr(8'h02, 8'hff);
    wr(8'h03, 8'hff);
    wr(8'h00, 8'h04);
    idle(4);
    chk(irq === 1'b1, "overflow irq");
    rd(8'h03, v);
    chk(v === 8'hff, "16-bit reload");
    // 256 cycles to the next wrap, so flags must hold on their own
    idle(40);
    rd(8'h00, v);
    chk(v[7:6] === 2'b11, "flags held");
    wr(8'h00, 8'h00);
    idle(2);
    chk(irq === 1'b0, "flags cleared");
    wr(8'h02, 8'hff);
    wr(8'h03, 8'h00);
    wr(8'h00, 8'h04);
    idle(4);
    rd(8'h00, v);
    chk(v[7:6] === 2'b01, "low wrap only");
    chk(irq === 1'b0, "low irq gated");
    wr(8'h00, 8'h64);
    idle(2);
    chk(irq === 1'b1, "low irq enabled");
    wr(8'h00, 8'h00);
    $display("t_wide done");
  endtask

  task automatic t_split();
    wr(8'h01, 8'h30);
    wr(8'h04, 8'h10);
    wr(8'h05, 8'h20);
    wr(8'h02, 8'hff);
    wr(8'h03, 8'hff);
    wr(8'h00, 8'h08);
    idle(6);
    rd(8'h03, v);
    chk(v === 8'hff, "high half stopped");
    rd(8'h02, v);
    chk(v >= 8'h10 && v < 8'h30, "low half reload");
    rd(8'h00, v);
    chk(v[7:6] === 2'b01, "split low flag");
    chk(irq === 1'b0, "split low irq gated");
    wr(8'h00, 8'h4c);
    idle(4);
    rd(8'h00, v);
    chk(v[7:6] === 2'b11, "split high flag");
    chk(irq === 1'b1, "split high irq");
    rd(8'h03, v);
    chk(v >= 8'h20 && v < 8'h30, "high half reload");
    wr(8'h00, 8'h00);
    $display("t_split done");
  endtask

  task automatic t_status();
    wr(8'h06, 8'h00);
    idle(2);
    chk(irq === 1'b0, "status masked");
    wr(8'h08, 8'h02);
    idle(2);
    chk(irq === 1'b1, "status unmasked");
    rd(8'h07, v);
    chk(v[1:0] === 2'b11, "status bits");
    idle(1);
    chk(irq === 1'b0, "status read clears");
    rd(8'h07, v);
    chk(v === 8'h00, "status empty");
    wr(8'h08, 8'h00);
    $display("t_status done");
  endtask

  task automatic t_sources();
    wr(8'h01, 8'h00);
    wr(8'h02, 8'h00);
    wr(8'h03, 8'h00);
    wr(8'h00, 8'h04);
    idle(120);
    wr(8'h00, 8'h00);
    rd(8'h02, v);
    chk(v >= 8'h09 && v <= 8'h0b, "div12 rate");
    wr(8'h02, 8'h00);
    wr(8'h00, 8'h06);
    idle(60);
    rd(8'h02, v);
    chk(v === 8'h00, "reserved source");
    wr(8'h00, 8'h07);
    cmp_pulses(5);
    idle(6);
    rd(8'h02, v);
    chk(v === 8'h05, "comparator source");
    wr(8'h02, 8'h00);
    wr(8'h00, 8'h05);
    rtc_cycles(16);
    idle(8);
    rd(8'h02, v);
    chk(v === 8'h02, "rtc div8 source");
    wr(8'h00, 8'h00);
    $display("t_sources done");
  endtask

  task automatic t_capture();
    wr(8'h01, 8'h10);
    wr(8'h06, 8'h01);
    wr(8'h04, 8'h00);
    wr(8'h05, 8'h00);
    wr(8'h02, 8'h00);
    wr(8'h03, 8'h00);
    wr(8'h00, 8'h17);
    @(posedge clk);
    #1;
    t0 = cycles;
    cmp_pulses(1);
    idle(6);
    rd(8'h04, cap1[7:0]);
    rd(8'h05, cap1[15:8]);
    rd(8'h00, v);
    chk(v[7] === 1'b1, "capture flag");
    chk(irq === 1'b1, "capture irq");
    // second rise exactly 100 clocks after the first
    while (cycles != t0 + 100) begin
      @(posedge clk);
      #1;
    end
    cmp_pulses(1);
    idle(6);
    rd(8'h04, cap2[7:0]);
    rd(8'h05, cap2[15:8]);
    chk(cap2 - cap1 === 16'h0064, "capture delta");
    wr(8'h00, 8'h00);
    wr(8'h03, 8'h10);
    wr(8'h05, 8'h00);
    wr(8'h00, 8'h14);
    rtc_cycles(8);
    idle(8);
    rd(8'h00, v);
    chk(v[7] === 1'b1, "rtc capture flag");
    rd(8'h05, v);
    chk(v === 8'h10, "rtc capture value");
    wr(8'h00, 8'h00);
    $display("t_capture done");
  endtask

  // ============================================================
  // main sequence
  initial begin
    rstn = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    rtc_clk_in = 1'b0;
    comparator_in = 1'b0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_wide();
    t_split();
    t_status();
    t_sources();
    t_capture();
    end_sim();
  end
endmodule // srct_timer_bench
`default_nettype wire
